/* File: rtc_consts.svh */
// Constants of the real-time clock block: register indices, control bit
// positions and counting limits.
// Assumes inclusion by bare name from every file that needs them.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Register indices; byte address is four times the index
`define RTC_IDX_CTRL   6'h00
`define RTC_IDX_PRE_LO 6'h06
`define RTC_IDX_PRE_HI 6'h08
`define RTC_IDX_DIV_LO 6'h0a
`define RTC_IDX_DIV_HI 6'h0c
`define RTC_IDX_CNT_LO 6'h0e
`define RTC_IDX_CNT_HI 6'h10
`define RTC_IDX_ALM_LO 6'h12
`define RTC_IDX_ALM_HI 6'h14

// Control register bit positions
`define RTC_B_TFLAG  0
`define RTC_B_TEN    1
`define RTC_B_AFLAG  2
`define RTC_B_AEN    3
`define RTC_B_OFF    7
`define RTC_B_SRC    8

// Address decode: word index bits, upper bits must be zero
`define RTC_ADDR_IDX_HI 7
`define RTC_ADDR_IDX_LO 2
`define RTC_HTRANS_ACT  1

// Fixed divide-by-64 stage and programmable divider limits
`define RTC_FIXED_LAST 6'h3f
`define RTC_DIV_ONE    20'h00001

`endif

/* File: rtc_pkg.sv */
// Types shared by the real-time clock block.
// Assumes nothing of its surroundings.
`default_nettype none

package rtc_pkg;
    typedef enum logic {SRC_MAIN, SRC_LOWPOWER} clkSrc_e;
    typedef logic [5:0]  regIdx_t;
    typedef logic [19:0] prescale_t;
endpackage

`default_nettype wire

/* File: rtc_osc_edge.sv */
// Oscillator level synchroniser and rising-edge detector.
// Assumes the oscillator runs below half of clk_sys.
`default_nettype none

module rtc_osc_edge (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic oscIn,
    output logic      edgePulse
);
    logic       sync1_ff;
    logic       sync2_ff;
    logic       last_ff;
    logic       edge_ff;
    logic       nxt_edge;
    logic [2:0] fill_ff;
    logic [2:0] nxt_fill;

    // No edge until last_ff holds a real sample: a pin high at release is no edge
    always_comb begin
        nxt_fill = {fill_ff[1:0], 1'b1};
        nxt_edge = sync2_ff & ~last_ff & fill_ff[2];
    end

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            last_ff  <= 1'b0;
            edge_ff  <= 1'b0;
            fill_ff  <= 3'h0;
        end else begin
            sync1_ff <= oscIn;
            sync2_ff <= sync1_ff;
            last_ff  <= sync2_ff;
            edge_ff  <= nxt_edge;
            fill_ff  <= nxt_fill;
        end
    end

    assign edgePulse = edge_ff;
endmodule // rtc_osc_edge

`default_nettype wire

/* File: rtc_prescaler_counter_alarm.sv */
// Real-time clock: oscillator prescaler, 20-bit divider, 32-bit time
// counter, alarm compare and an AHB-Lite register slave.
// Assumes a single AHB-Lite master and free-running oscillator levels.
`include "rtc_consts.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module rtc_prescaler_counter_alarm (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        mainOscInput,
    input  wire logic        lowpowerOscInput,
    input  wire logic        powerDownActive,
    output logic             tickIrqRequest,
    output logic             alarmIrqRequest,
    output logic             mainOscOff,
    output logic             lowpowerOscOff
);
    import rtc_pkg::*;

    function automatic logic regHit(input logic [31:0] addr, input regIdx_t idx);
        regHit = (addr[31:`RTC_ADDR_IDX_HI+1] == '0) &&
                 (addr[`RTC_ADDR_IDX_HI:`RTC_ADDR_IDX_LO] == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Oscillator edges
    logic [1:0] oscLevel;
    logic [1:0] oscEdge;
    logic       selEdge;

    assign oscLevel = {lowpowerOscInput, mainOscInput};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_osc
            rtc_osc_edge u_edge (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .oscIn     (oscLevel[gi]),
                .edgePulse (oscEdge[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic        dataPhase_ff;
    logic        nxt_dataPhase;
    logic        dataWrite_ff;
    logic        nxt_dataWrite;
    logic [31:0] dataAddr_ff;
    logic [31:0] nxt_dataAddr;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        readyOut_ff;
    logic        respErr_ff;
    logic        busWrite;

    // Control state
    logic        tickFlag_ff;
    logic        nxt_tickFlag;
    logic        tickEn_ff;
    logic        nxt_tickEn;
    logic        alarmFlag_ff;
    logic        nxt_alarmFlag;
    logic        alarmEn_ff;
    logic        nxt_alarmEn;
    logic        off_ff;
    logic        nxt_off;
    clkSrc_e     clkSrc_ff;
    clkSrc_e     nxt_clkSrc;
    logic        wrCtrl;

    // Time keeping state, never reset
    logic [5:0]  fixed64_ff;
    logic [5:0]  nxt_fixed64;
    prescale_t   divider_ff;
    prescale_t   nxt_divider;
    logic [3:0]  preUpper_ff;
    logic [3:0]  nxt_preUpper;
    logic [15:0] preLower_ff;
    logic [15:0] nxt_preLower;
    logic [15:0] cntLower_ff;
    logic [15:0] nxt_cntLower;
    logic [15:0] cntUpper_ff;
    logic [15:0] nxt_cntUpper;
    logic [15:0] alarmLower_ff;
    logic [15:0] nxt_alarmLower;
    logic [15:0] alarmUpper_ff;
    logic [15:0] nxt_alarmUpper;
    logic        tickEvent;
    logic        alarmEvent;
    logic        divStep;

    // Outputs
    logic        tickIrq_ff;
    logic        alarmIrq_ff;
    logic        mainOff_ff;
    logic        lpOff_ff;

    assign busWrite = dataPhase_ff & dataWrite_ff;
    assign wrCtrl   = busWrite & regHit(dataAddr_ff, `RTC_IDX_CTRL);

    // Zero wait states; read data registered in the address phase
    always_comb begin
        nxt_dataPhase = 1'b0;
        nxt_dataWrite = 1'b0;
        nxt_dataAddr  = dataAddr_ff;
        nxt_rdata     = rdata_ff;
        if (hsel && htrans[`RTC_HTRANS_ACT] && hready) begin
            nxt_dataPhase = 1'b1;
            nxt_dataWrite = hwrite;
            nxt_dataAddr  = haddr;
            nxt_rdata     = '0;
            if (regHit(haddr, `RTC_IDX_CTRL)) begin
                nxt_rdata[`RTC_B_TFLAG] = tickFlag_ff;
                nxt_rdata[`RTC_B_TEN]   = tickEn_ff;
                nxt_rdata[`RTC_B_AFLAG] = alarmFlag_ff;
                nxt_rdata[`RTC_B_AEN]   = alarmEn_ff;
                nxt_rdata[`RTC_B_OFF]   = off_ff;
                nxt_rdata[`RTC_B_SRC]   = (clkSrc_ff == SRC_LOWPOWER);
            end else if (regHit(haddr, `RTC_IDX_PRE_LO)) begin
                nxt_rdata[15:0] = preLower_ff;
            end else if (regHit(haddr, `RTC_IDX_PRE_HI)) begin
                nxt_rdata[3:0] = preUpper_ff;
            end else if (regHit(haddr, `RTC_IDX_DIV_LO)) begin
                nxt_rdata[15:0] = divider_ff[15:0];
            end else if (regHit(haddr, `RTC_IDX_DIV_HI)) begin
                nxt_rdata[3:0] = divider_ff[19:16];
            end else if (regHit(haddr, `RTC_IDX_CNT_LO)) begin
                nxt_rdata[15:0] = cntLower_ff;
            end else if (regHit(haddr, `RTC_IDX_CNT_HI)) begin
                nxt_rdata[15:0] = cntUpper_ff;
            end else if (regHit(haddr, `RTC_IDX_ALM_LO)) begin
                nxt_rdata[15:0] = alarmLower_ff;
            end else if (regHit(haddr, `RTC_IDX_ALM_HI)) begin
                nxt_rdata[15:0] = alarmUpper_ff;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dataPhase_ff <= 1'b0;
            dataWrite_ff <= 1'b0;
            dataAddr_ff  <= '0;
            rdata_ff     <= '0;
            readyOut_ff  <= 1'b0;
            respErr_ff   <= 1'b0;
        end else begin
            dataPhase_ff <= nxt_dataPhase;
            dataWrite_ff <= nxt_dataWrite;
            dataAddr_ff  <= nxt_dataAddr;
            rdata_ff     <= nxt_rdata;
            readyOut_ff  <= 1'b1;
            respErr_ff   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler chain and time counter
    // Source select after the synchronisers; a switch may lose one edge
    assign selEdge = (clkSrc_ff == SRC_LOWPOWER) ? oscEdge[1] : oscEdge[0];
    assign divStep = selEdge & ~off_ff & (fixed64_ff == `RTC_FIXED_LAST);

    always_comb begin
        nxt_fixed64    = fixed64_ff;
        nxt_divider    = divider_ff;
        nxt_preUpper   = preUpper_ff;
        nxt_preLower   = preLower_ff;
        nxt_cntLower   = cntLower_ff;
        nxt_cntUpper   = cntUpper_ff;
        nxt_alarmLower = alarmLower_ff;
        nxt_alarmUpper = alarmUpper_ff;
        tickEvent      = 1'b0;
        alarmEvent     = 1'b0;
        if (off_ff) begin
            // Stopped chain restarts with the divider at the stored value, first tick one divider step short of a full period
            nxt_fixed64 = '0;
            nxt_divider = {preUpper_ff, preLower_ff};
        end else if (selEdge) begin
            nxt_fixed64 = fixed64_ff + 6'h01;
            if (divStep) begin
                if (divider_ff == `RTC_DIV_ONE) begin
                    nxt_divider = {preUpper_ff, preLower_ff};
                end else begin
                    nxt_divider = divider_ff - `RTC_DIV_ONE;
                end
                // A stored value of one never ticks, as the divider never leaves one
                tickEvent = (divider_ff != `RTC_DIV_ONE) &&
                            (nxt_divider == `RTC_DIV_ONE);
            end
        end
        if (tickEvent) begin
            {nxt_cntUpper, nxt_cntLower} = {cntUpper_ff, cntLower_ff} + 32'h1;
            alarmEvent = ({nxt_cntUpper, nxt_cntLower} ==
                          {alarmUpper_ff, alarmLower_ff});
        end
        // Protected writes only land while the chain is stopped
        if (busWrite && off_ff) begin
            if (regHit(dataAddr_ff, `RTC_IDX_PRE_LO)) begin
                nxt_preLower = hwdata[15:0];
            end else if (regHit(dataAddr_ff, `RTC_IDX_PRE_HI)) begin
                nxt_preUpper = hwdata[3:0];
            end else if (regHit(dataAddr_ff, `RTC_IDX_CNT_LO)) begin
                nxt_cntLower = hwdata[15:0];
            end else if (regHit(dataAddr_ff, `RTC_IDX_CNT_HI)) begin
                nxt_cntUpper = hwdata[15:0];
            end
        end
        if (busWrite) begin
            if (regHit(dataAddr_ff, `RTC_IDX_ALM_LO)) begin
                nxt_alarmLower = hwdata[15:0];
            end else if (regHit(dataAddr_ff, `RTC_IDX_ALM_HI)) begin
                nxt_alarmUpper = hwdata[15:0];
            end
        end
    end

    // No reset: the time survives any system reset
    always_ff @(posedge clk_sys) begin
        fixed64_ff    <= nxt_fixed64;
        divider_ff    <= nxt_divider;
        preUpper_ff   <= nxt_preUpper;
        preLower_ff   <= nxt_preLower;
        cntLower_ff   <= nxt_cntLower;
        cntUpper_ff   <= nxt_cntUpper;
        alarmLower_ff <= nxt_alarmLower;
        alarmUpper_ff <= nxt_alarmUpper;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; a new event wins over a same-cycle clear
    always_comb begin
        nxt_tickEn   = tickEn_ff;
        nxt_alarmEn  = alarmEn_ff;
        nxt_off      = off_ff;
        nxt_clkSrc   = clkSrc_ff;
        nxt_tickFlag = tickFlag_ff;
        nxt_alarmFlag = alarmFlag_ff;
        if (wrCtrl) begin
            nxt_tickEn   = hwdata[`RTC_B_TEN];
            nxt_alarmEn  = hwdata[`RTC_B_AEN];
            nxt_off      = hwdata[`RTC_B_OFF];
            nxt_clkSrc   = hwdata[`RTC_B_SRC] ? SRC_LOWPOWER : SRC_MAIN;
            nxt_tickFlag  = tickFlag_ff & ~hwdata[`RTC_B_TFLAG];
            nxt_alarmFlag = alarmFlag_ff & ~hwdata[`RTC_B_AFLAG];
        end
        nxt_tickFlag  = nxt_tickFlag | tickEvent;
        nxt_alarmFlag = nxt_alarmFlag | alarmEvent;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickEn_ff    <= 1'b0;
            alarmEn_ff   <= 1'b0;
            off_ff       <= 1'b0;
            clkSrc_ff    <= SRC_MAIN;
            tickFlag_ff  <= 1'b0;
            alarmFlag_ff <= 1'b0;
        end else begin
            tickEn_ff    <= nxt_tickEn;
            alarmEn_ff   <= nxt_alarmEn;
            off_ff       <= nxt_off;
            clkSrc_ff    <= nxt_clkSrc;
            tickFlag_ff  <= nxt_tickFlag;
            alarmFlag_ff <= nxt_alarmFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request lines and oscillator controls
    // Main oscillator keeps running in power-down unless the block is off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickIrq_ff  <= 1'b0;
            alarmIrq_ff <= 1'b0;
            mainOff_ff  <= 1'b0;
            lpOff_ff    <= 1'b0;
        end else begin
            tickIrq_ff  <= tickFlag_ff & tickEn_ff;
            alarmIrq_ff <= alarmFlag_ff & alarmEn_ff;
            mainOff_ff  <= powerDownActive & off_ff;
            lpOff_ff    <= powerDownActive & off_ff;
        end
    end

    assign hreadyout       = readyOut_ff;
    assign hresp           = respErr_ff;
    assign hrdata          = rdata_ff;
    assign tickIrqRequest  = tickIrq_ff;
    assign alarmIrqRequest = alarmIrq_ff;
    assign mainOscOff      = mainOff_ff;
    assign lowpowerOscOff  = lpOff_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_tickAtOne;
        @(posedge clk_sys) disable iff (!rst_n)
        tickEvent |=> (divider_ff == `RTC_DIV_ONE) && tickFlag_ff;
    endproperty
    a_tickAtOne: assert property (p_tickAtOne) else $error("tick without divider at one");

    property p_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        (divStep && divider_ff == `RTC_DIV_ONE) |=>
            (divider_ff == {$past(preUpper_ff), $past(preLower_ff)});
    endproperty
    a_reload: assert property (p_reload) else $error("divider did not reload");

    property p_fixedStage;
        @(posedge clk_sys) disable iff (!rst_n)
        (!off_ff && !$past(off_ff) && $changed(divider_ff)) |->
            ($past(fixed64_ff) == `RTC_FIXED_LAST);
    endproperty
    a_fixedStage: assert property (p_fixedStage) else $error("divider stepped early");

    property p_tickOut;
        @(posedge clk_sys) disable iff (!rst_n)
        (tickEvent && tickEn_ff && !wrCtrl) |=> ##1 tickIrqRequest;
    endproperty
    a_tickOut: assert property (p_tickOut) else $error("tick request missing");

    property p_clearFlag;
        @(posedge clk_sys) disable iff (!rst_n)
        (wrCtrl && hwdata[`RTC_B_TFLAG] && !tickEvent) |=> !tickFlag_ff;
    endproperty
    a_clearFlag: assert property (p_clearFlag) else $error("tick flag not cleared");

    property p_alarmMatch;
        @(posedge clk_sys) disable iff (!rst_n)
        alarmEvent |=> alarmFlag_ff &&
            ({cntUpper_ff, cntLower_ff} == {$past(alarmUpper_ff), $past(alarmLower_ff)});
    endproperty
    a_alarmMatch: assert property (p_alarmMatch) else $error("alarm flag mismatch");

    property p_carry;
        @(posedge clk_sys) disable iff (!rst_n)
        (tickEvent && cntLower_ff == 16'hffff) |=>
            (cntLower_ff == 16'h0000) && (cntUpper_ff == $past(cntUpper_ff) + 16'h0001);
    endproperty
    a_carry: assert property (p_carry) else $error("upper counter missed carry");

    property p_offFreeze;
        @(posedge clk_sys) disable iff (!rst_n)
        (off_ff && !busWrite) |=> $stable(cntLower_ff) && $stable(cntUpper_ff);
    endproperty
    a_offFreeze: assert property (p_offFreeze) else $error("counter moved while off");

    property p_protect;
        @(posedge clk_sys) disable iff (!rst_n)
        (busWrite && !off_ff) |=> $stable(preLower_ff) && $stable(preUpper_ff);
    endproperty
    a_protect: assert property (p_protect) else $error("protected write landed");

    property p_oscOff;
        @(posedge clk_sys) disable iff (!rst_n)
        (powerDownActive && off_ff) |=> mainOscOff && lowpowerOscOff;
    endproperty
    a_oscOff: assert property (p_oscOff) else $error("oscillators not stopped");

    property p_mainRuns;
        @(posedge clk_sys) disable iff (!rst_n)
        !off_ff |=> !mainOscOff;
    endproperty
    a_mainRuns: assert property (p_mainRuns) else $error("main oscillator stopped");
endmodule // rtc_prescaler_counter_alarm

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the real-time clock block: AHB-Lite register
// access, tick and alarm requests, write protection and the off bit.
// Assumes the design files are compiled first and share rtc_consts.svh.
`include "rtc_consts.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;

    logic        clk_sys;
    logic        rst_n;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [2:0]  oscDiv;
    logic        powerDown;
    logic        tickIrqRequest;
    logic        alarmIrqRequest;
    logic        mainOscOff;
    logic        lowpowerOscOff;
    integer      seed;
    int          nFail;
    int          nCompared;
    int          cyc;
    logic [31:0] rd;
    logic [31:0] cntSnap;
    logic [15:0] cntHi;
    logic [19:0] pre;
    int          t1;
    int          t2;
    logic        sawHigh;

    // Main osc toggles every 2 clocks, low-power every 4: both below 10 MHz
    rtc_prescaler_counter_alarm u_dut (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .hsel             (1'b1),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (3'b010),
        .hwdata           (hwdata),
        .hready           (hreadyout),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .hrdata           (hrdata),
        .mainOscInput     (oscDiv[1]),
        .lowpowerOscInput (oscDiv[2]),
        .powerDownActive  (powerDown),
        .tickIrqRequest   (tickIrqRequest),
        .alarmIrqRequest  (alarmIrqRequest),
        .mainOscOff       (mainOscOff),
        .lowpowerOscOff   (lowpowerOscOff)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        oscDiv <= oscDiv + 3'h1;
        cyc    <= cyc + 1;
    end

    function automatic logic [31:0] addrOf(input regIdx_t idx);
        return {24'h0, idx, 2'b00};
    endfunction

    // Clocks between ticks: fixed /64 stage times prescaler times osc period
    function automatic int tickCycles(input logic [19:0] p, input int oscPer);
        return 64 * int'(p) * oscPer;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic reportAndStop();
        $display("compared %0d, failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Single transfer; entered just after a rising edge, leaves on one
    task automatic bus_xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                            output logic [31:0] rdata);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic bus_wr(input regIdx_t idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus_xfer(addrOf(idx), 1'b1, wd, dummy);
        // Idle cycle so a following read sees the new value
        @(posedge clk_sys);
    endtask

    task automatic bus_rd(input regIdx_t idx, output logic [31:0] rdata);
        bus_xfer(addrOf(idx), 1'b0, 32'h0, rdata);
    endtask

    task automatic wait_tick(output int t);
        int g;
        g = 0;
        while (tickIrqRequest !== 1'b1 && g < 4000) begin
            @(posedge clk_sys);
            g++;
        end
        t = cyc;
        check({31'h0, tickIrqRequest}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h1196;
        nFail = 0;
        nCompared = 0;
        cyc = 0;
        oscDiv = 3'h0;
        rst_n = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        powerDown = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus_rd(`RTC_IDX_CTRL, rd);
        check(rd, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus_wr(`RTC_IDX_CTRL, 32'h80);
        pre = 20'h2 + 20'($random(seed) & 1);
        cntHi = 16'($random(seed));
        bus_wr(`RTC_IDX_PRE_LO, {12'h0, pre});
        bus_wr(`RTC_IDX_PRE_HI, 32'hfff0);
        bus_wr(`RTC_IDX_CNT_LO, 32'hfffe);
        bus_wr(`RTC_IDX_CNT_HI, {16'h0, cntHi});
        bus_wr(`RTC_IDX_ALM_LO, 32'h0);
        bus_wr(`RTC_IDX_ALM_HI, {16'h0, cntHi + 16'h1});
        bus_rd(`RTC_IDX_PRE_LO, rd);
        check(rd, {12'h0, pre});
        bus_rd(`RTC_IDX_PRE_HI, rd);
        check(rd, 32'h0);
        bus_rd(`RTC_IDX_CNT_HI, rd);
        check(rd, {16'h0, cntHi});
        bus_rd(`RTC_IDX_DIV_LO, rd);
        check(rd, {12'h0, pre});
        // Unmapped word: write ignored, reads zero
        t1 = 8'h16 + ($random(seed) & 8'h0f);
        bus_wr(regIdx_t'(t1), $random(seed));
        bus_rd(regIdx_t'(t1), rd);
        check(rd, 32'h0);
        bus_wr(`RTC_IDX_CTRL, 32'h0a);
        bus_wr(`RTC_IDX_CNT_LO, 32'h1234);
        bus_rd(`RTC_IDX_CNT_LO, rd);
        check(rd, 32'hfffe);
        wait_tick(t1);
        check({31'h0, alarmIrqRequest}, 32'h0);
        bus_rd(`RTC_IDX_CNT_LO, rd);
        check(rd, 32'hffff);
        bus_wr(`RTC_IDX_CTRL, 32'h0b);
        repeat (2) @(posedge clk_sys);
        check({31'h0, tickIrqRequest}, 32'h0);
        wait_tick(t2);
        check(32'(t2 - t1), 32'(tickCycles(pre, 4)));
        check({31'h0, alarmIrqRequest}, 32'h1);
        bus_rd(`RTC_IDX_CNT_HI, rd);
        check(rd, {16'h0, cntHi + 16'h1});
        bus_rd(`RTC_IDX_DIV_LO, rd);
        check({31'h0, rd >= 32'h1 && rd <= {12'h0, pre}}, 32'h1);
        bus_wr(`RTC_IDX_CTRL, 32'h0f);
        repeat (2) @(posedge clk_sys);
        check({30'h0, tickIrqRequest, alarmIrqRequest}, 32'h0);
        // Enables off: a tick sets the flag but raises no request
        bus_wr(`RTC_IDX_CTRL, 32'h00);
        sawHigh = 1'b0;
        repeat (tickCycles(pre, 4) + 60) begin
            @(posedge clk_sys);
            sawHigh = sawHigh | tickIrqRequest;
        end
        check({31'h0, sawHigh}, 32'h0);
        bus_rd(`RTC_IDX_CTRL, rd);
        check(rd, 32'h1);
        powerDown <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({30'h0, mainOscOff, lowpowerOscOff}, 32'h0);
        bus_wr(`RTC_IDX_CTRL, 32'h80);
        repeat (2) @(posedge clk_sys);
        check({30'h0, mainOscOff, lowpowerOscOff}, 32'h3);
        powerDown <= 1'b0;
        bus_rd(`RTC_IDX_CNT_LO, cntSnap);
        repeat (tickCycles(pre, 4) + 60) @(posedge clk_sys);
        bus_rd(`RTC_IDX_CNT_LO, rd);
        check(rd, cntSnap);
        // Reset while the chain is stopped keeps time and prescaler
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        bus_rd(`RTC_IDX_CTRL, rd);
        check(rd, 32'h0);
        bus_rd(`RTC_IDX_CNT_LO, rd);
        check(rd, cntSnap);
        bus_rd(`RTC_IDX_PRE_LO, rd);
        check(rd, {12'h0, pre});
        // Low-power source: osc period 8 clocks instead of 4
        bus_wr(`RTC_IDX_CTRL, 32'h102);
        wait_tick(t1);
        bus_wr(`RTC_IDX_CTRL, 32'h103);
        repeat (2) @(posedge clk_sys);
        wait_tick(t2);
        check(32'(t2 - t1), 32'(tickCycles(pre, 8)));
        reportAndStop();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        nFail++;
        $display("[FAIL] t=%0t seen=%h expected=%h", $time, 32'h0, 32'h1);
        reportAndStop();
    end
endmodule // tb

`default_nettype wire
